// ### rtl/hscpc_top.sv
// hub strap decode, upstream pullup timing and port power control
// How it works
// - a low power source strap means bus powered, a high one self powered.
// - after reset or a strap change the pullup output floats until the timer ends.
// - after the timer ends the pullup output is driven high until the next restart.
// - only the system reset or a strap change restarts the timer; a bus reset has no effect on it.
// - the hold-off lasts three milliseconds.
// - with the memory strap high the memory interface is off and its clock not driven.
// - with the memory strap low the memory clock is always driven, from the memory control clock bit.
// - with the memory strap low the shared pin is the memory's two-way data line.
// - with the memory strap high the shared pin is read as the gang or per-port strap.
// - with the memory interface off the built-in identifiers are reported.
// - ganged overcurrent removes power from all ports, per-port only from its own.
// - port zero is the upstream port, the numbered pairs are downstream.
`timescale 1ns/1ps
`default_nettype none
module hscpc_top
    import hscpc_pkg::*;
#(
    parameter int HOLDOFF = HOLDOFF_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic power_source_strap_n,
    input wire logic ext_memory_disable,
    output logic self_powered,
    output logic upstream_pullup_ctrl_o,
    output logic upstream_pullup_ctrl_oe,
    output logic serial_mem_clock_o,
    output logic serial_mem_clock_oe,
    input wire logic serial_mem_data_or_gang_strap_i,
    output logic serial_mem_data_or_gang_strap_o,
    output logic serial_mem_data_or_gang_strap_oe,
    input wire logic [NUM_DOWN-1:0] overcurrent_n,
    output logic [NUM_DOWN-1:0] port_power_n
);
    // ----------------------------------------------------------------
    // strap synchroniser and hold-off timer
    // ----------------------------------------------------------------
    hscpc_link_if link ();

    hscpc_strap_sync u_strap (
        .aclk(aclk),
        .aresetn(aresetn),
        .strap_raw(power_source_strap_n),
        .link(link)
    );

    hscpc_holdoff_timer #(.CYCLES(HOLDOFF)) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .link(link)
    );

    // ----------------------------------------------------------------
    // pin decode
    // ----------------------------------------------------------------
    logic ext_dis;
    logic gang_mode;
    logic [2:0] mem_ctrl;
    logic [NUM_DOWN-1:0] power_req;
    logic [NUM_DOWN-1:0] trip;
    logic [NUM_DOWN-1:0] trip_clr;
    logic [31:0] id_load;

    // no bus reset input exists, so nothing but aresetn and the strap change reaches the timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            self_powered <= 1'b0;
            upstream_pullup_ctrl_o <= 1'b0;
            upstream_pullup_ctrl_oe <= 1'b0;
        end else begin
            self_powered <= link.strap_level;
            upstream_pullup_ctrl_o <= 1'b1;
            upstream_pullup_ctrl_oe <= link.holdoff_done && !link.strap_change;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_dis <= 1'b1;
            gang_mode <= 1'b0;
        end else begin
            ext_dis <= ext_memory_disable;
            gang_mode <= ext_memory_disable && serial_mem_data_or_gang_strap_i;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_mem_clock_o <= 1'b0;
            serial_mem_clock_oe <= 1'b0;
            serial_mem_data_or_gang_strap_o <= 1'b0;
            serial_mem_data_or_gang_strap_oe <= 1'b0;
        end else begin
            serial_mem_clock_o <= mem_ctrl[MC_CLK];
            serial_mem_clock_oe <= !ext_memory_disable;
            serial_mem_data_or_gang_strap_o <= mem_ctrl[MC_DOUT];
            serial_mem_data_or_gang_strap_oe <= !ext_memory_disable && mem_ctrl[MC_DOE];
        end
    end

    // ----------------------------------------------------------------
    // downstream port power, index i is port i+1
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DOWN; gi++) begin : g_port
            logic hit;
            assign hit = !overcurrent_n[gi] || (gang_mode && !(&overcurrent_n));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    trip[gi] <= 1'b0;
                    port_power_n[gi] <= 1'b1;
                end else begin
                    trip[gi] <= hit || (trip[gi] && !trip_clr[gi]);
                    port_power_n[gi] <= !(power_req[gi] && !trip[gi]);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstr;
    logic do_write;
    logic [31:0] id_value;
    logic [31:0] status;

    assign do_write = aw_held && w_held && !bvalid;
    assign id_value = ext_dis ? {DEFAULT_PID, DEFAULT_VID} : id_load;

    always_comb begin
        status = '0;
        status[ST_SELF] = link.strap_level;
        status[ST_PULLUP] = upstream_pullup_ctrl_oe;
        status[ST_EXTDIS] = ext_dis;
        status[ST_GANG] = gang_mode;
        status[ST_MEMDIN] = serial_mem_data_or_gang_strap_i;
        status[ST_PWR_LSB +: NUM_DOWN] = ~port_power_n;
        status[ST_TRIP_LSB +: NUM_DOWN] = trip;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_held <= 1'b0;
            waddr <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            waddr <= awaddr;
        end else begin
            if (do_write) aw_held <= 1'b0;
            if (bvalid && bready) awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            w_held <= 1'b0;
            wdat <= '0;
            wstr <= '0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_held <= 1'b1;
            wdat <= wdata;
            wstr <= wstrb;
        end else begin
            if (do_write) w_held <= 1'b0;
            if (bvalid && bready) wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= (waddr == MEM_CTRL_OFS || waddr == PORT_CTRL_OFS ||
                      waddr == TRIP_CLR_OFS || waddr == ID_LOAD_OFS) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_ctrl <= MEM_CTRL_RST;
            power_req <= '0;
            id_load <= {DEFAULT_PID, DEFAULT_VID};
        end else if (do_write) begin
            if (waddr == MEM_CTRL_OFS && wstr[0]) mem_ctrl <= wdat[2:0];
            if (waddr == PORT_CTRL_OFS && wstr[0]) power_req <= wdat[NUM_DOWN-1:0];
            for (int b = 0; b < 4; b++) begin
                if (waddr == ID_LOAD_OFS && wstr[b]) id_load[b*8 +: 8] <= wdat[b*8 +: 8];
            end
        end
    end

    // trip clear lasts one cycle; a new overcurrent in that cycle still sets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_clr <= '0;
        end else begin
            trip_clr <= (do_write && waddr == TRIP_CLR_OFS && wstr[0]) ? wdat[NUM_DOWN-1:0] : '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            unique case (araddr)
                STATUS_OFS: rdata <= status;
                MEM_CTRL_OFS: rdata <= {29'h0, mem_ctrl};
                PORT_CTRL_OFS: rdata <= {{(32-NUM_DOWN){1'b0}}, power_req};
                TRIP_CLR_OFS: rdata <= '0;
                ID_OFS: rdata <= id_value;
                ID_LOAD_OFS: rdata <= id_load;
                default: begin
                    rdata <= '0;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [31:0] holdoff_age;

    always_ff @(posedge aclk) begin
        if (!aresetn || link.strap_change) begin
            holdoff_age <= '0;
        end else if (holdoff_age <= 32'(HOLDOFF)) begin
            holdoff_age <= holdoff_age + 32'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_self_powered_map: assert property ($changed(link.strap_level) |=> self_powered == $past(link.strap_level))
        else $error("self powered flag does not follow strap");
    chk_pullup_floats: assert property (holdoff_age <= 32'(HOLDOFF) |-> !upstream_pullup_ctrl_oe)
        else $error("pullup driven during hold-off");
    chk_pullup_driven: assert property (holdoff_age > 32'(HOLDOFF) |-> upstream_pullup_ctrl_oe && upstream_pullup_ctrl_o)
        else $error("pullup not driven high after hold-off");
    chk_strap_restart: assert property ($changed(link.strap_level) |-> ##2 !upstream_pullup_ctrl_oe)
        else $error("strap change did not release pullup");
    chk_mem_clock_off: assert property (ext_memory_disable |=> !serial_mem_clock_oe && !serial_mem_data_or_gang_strap_oe)
        else $error("memory pins driven while memory disabled");
    chk_mem_clock_on: assert property (!ext_memory_disable |=> serial_mem_clock_oe && serial_mem_clock_o == $past(mem_ctrl[MC_CLK]))
        else $error("memory clock not driven");
    chk_mem_data_drive: assert property (!ext_memory_disable && mem_ctrl[MC_DOE] |=> serial_mem_data_or_gang_strap_oe && serial_mem_data_or_gang_strap_o == $past(mem_ctrl[MC_DOUT]))
        else $error("memory data not driven");
    chk_gang_strap: assert property (ext_memory_disable |=> gang_mode == $past(serial_mem_data_or_gang_strap_i))
        else $error("gang strap not sampled");
    chk_gang_trip: assert property (gang_mode && !(&overcurrent_n) |-> ##2 (&port_power_n))
        else $error("ganged overcurrent left a port powered");
    chk_port_trip: assert property (!overcurrent_n[0] |-> ##2 port_power_n[0])
        else $error("overcurrent port left powered");

    cov_pullup_on: cover property ($rose(upstream_pullup_ctrl_oe));
    cov_strap_change: cover property (link.strap_change ##2 !upstream_pullup_ctrl_oe);
    cov_gang_trip: cover property (gang_mode && !overcurrent_n[0] ##2 (&port_power_n));
    cov_read: cover property (rvalid && rready && rresp == RESP_OKAY);
endmodule
`default_nettype wire

// ### rtl/hscpc_pkg.sv
// shared constants of the hub strap, attach and port power control block
package hscpc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 40000;
    localparam int HOLDOFF_MS = 3;
    localparam int HOLDOFF_CYCLES = HOLDOFF_MS * CLK_KHZ;
    localparam int SYNC_ARM_W = 3;

    // ----------------------------------------------------------------
    // ports and bus
    // ----------------------------------------------------------------
    localparam int NUM_DOWN = 3;
    localparam int ADDR_W = 8;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] MEM_CTRL_OFS = 8'h04;
    localparam logic [7:0] PORT_CTRL_OFS = 8'h08;
    localparam logic [7:0] TRIP_CLR_OFS = 8'h0c;
    localparam logic [7:0] ID_OFS = 8'h10;
    localparam logic [7:0] ID_LOAD_OFS = 8'h14;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ST_SELF = 0;
    localparam int ST_PULLUP = 1;
    localparam int ST_EXTDIS = 2;
    localparam int ST_GANG = 3;
    localparam int ST_MEMDIN = 4;
    localparam int ST_PWR_LSB = 8;
    localparam int ST_TRIP_LSB = 12;
    localparam int MC_CLK = 0;
    localparam int MC_DOUT = 1;
    localparam int MC_DOE = 2;

    // ----------------------------------------------------------------
    // reset values and answers
    // ----------------------------------------------------------------
    localparam logic [2:0] MEM_CTRL_RST = 3'h0;
    // identifiers below are arbitrary values
    localparam logic [15:0] DEFAULT_VID = 16'h0a5a;
    localparam logic [15:0] DEFAULT_PID = 16'h0001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### rtl/hscpc_link_if.sv
// strap level, strap change and hold-off status between the block's parts
`timescale 1ns/1ps
`default_nettype none
interface hscpc_link_if;
    logic strap_level;
    logic strap_change;
    logic holdoff_done;

    modport strap (output strap_level, output strap_change);
    modport timer (input strap_change, output holdoff_done);
    modport ctrl (input strap_level, input strap_change, input holdoff_done);
endinterface
`default_nettype wire

// ### rtl/hscpc_strap_sync.sv
// power source strap synchroniser with change detection
`timescale 1ns/1ps
`default_nettype none
module hscpc_strap_sync
    import hscpc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic strap_raw,
    hscpc_link_if.strap link
);
    logic sync1;
    logic sync2;
    logic prev;
    logic [SYNC_ARM_W-1:0] arm;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync1 <= strap_raw;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // no change reported until the pipeline holds real samples
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm <= '0;
        end else begin
            arm <= {arm[SYNC_ARM_W-2:0], 1'b1};
        end
    end

    assign link.strap_level = sync2;
    assign link.strap_change = arm[SYNC_ARM_W-1] && (sync2 != prev);
endmodule
`default_nettype wire

// ### rtl/hscpc_holdoff_timer.sv
// pullup hold-off timer, restarted by reset or strap change
`timescale 1ns/1ps
`default_nettype none
module hscpc_holdoff_timer
    import hscpc_pkg::*;
#(
    parameter int CYCLES = HOLDOFF_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    hscpc_link_if.timer link
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] cnt;
    logic done;

    always_ff @(posedge aclk) begin
        if (!aresetn || link.strap_change) begin
            cnt <= '0;
            done <= 1'b0;
        end else if (!done) begin
            cnt <= cnt + CNT_W'(1);
            done <= (cnt == LAST);
        end
    end

    assign link.holdoff_done = done;
endmodule
`default_nettype wire

// ### test/hscpc_far_model.sv
// far side model: upstream host line, serial memory lines and board straps
`timescale 1ns/1ps
`default_nettype none
module hscpc_far_model (
    input wire logic pullup_o,
    input wire logic pullup_oe,
    input wire logic clock_o,
    input wire logic clock_oe,
    input wire logic data_o,
    input wire logic data_oe,
    input wire logic ext_memory_disable,
    input wire logic board_power_n,
    input wire logic board_gang,
    output logic power_source_strap_n,
    output logic data_in,
    output logic dplus_level,
    output logic clock_level
);
    // ----------------------------------------------------------------
    // line resolution
    // ----------------------------------------------------------------
    // host pulldown holds the upstream plus line low while floating
    assign dplus_level = pullup_oe ? pullup_o : 1'b0;
    // internal pulldown on the memory clock
    assign clock_level = clock_oe ? clock_o : 1'b0;
    assign power_source_strap_n = board_power_n;
    // strap wiring or memory data line; contention shows as unknown
    always_comb begin
        if (ext_memory_disable) begin
            data_in = data_oe ? 1'bx : board_gang;
        end else begin
            data_in = data_oe ? data_o : 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### test/tb_hscpc_top.sv
// self-checking bench of the strap, pullup and port power block
`timescale 1ns/1ps
`default_nettype none
module tb_hscpc_top
    import hscpc_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int HOLD = 20;
    typedef struct packed {
        logic strap_n;
        logic ext;
        logic gang;
        logic [2:0] mc;
        logic [4:0] exp;
    } hscpc_row_type;
    // exp: gang mode, clock oe, data oe, data pin level, clock level
    // last row drops the memory data drive before the memory strap goes high
    hscpc_row_type rows [6] = '{11'h200, 11'h7f2, 11'h5ef, 11'h069, 11'h1ce, 11'h312};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [ADDR_W-1:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic ext_memory_disable = 1'b1;
    logic board_power_n = 1'b0;
    logic board_gang = 1'b0;
    logic [NUM_DOWN-1:0] overcurrent_n = 3'h7;
    logic awready, wready, bvalid, arready, rvalid, self_powered, strap_n, data_in, dplus_level, clock_level;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic pu_o, pu_oe, clk_o, clk_oe, dat_o, dat_oe;
    logic [NUM_DOWN-1:0] port_power_n;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    int c;

    always #12.5 aclk = ~aclk;

    hscpc_top #(.HOLDOFF(HOLD)) i_hscpc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .power_source_strap_n(strap_n),
        .ext_memory_disable(ext_memory_disable), .self_powered(self_powered), .upstream_pullup_ctrl_o(pu_o),
        .upstream_pullup_ctrl_oe(pu_oe), .serial_mem_clock_o(clk_o), .serial_mem_clock_oe(clk_oe),
        .serial_mem_data_or_gang_strap_i(data_in), .serial_mem_data_or_gang_strap_o(dat_o),
        .serial_mem_data_or_gang_strap_oe(dat_oe), .overcurrent_n(overcurrent_n), .port_power_n(port_power_n));

    hscpc_far_model i_hscpc_far_model (.pullup_o(pu_o), .pullup_oe(pu_oe), .clock_o(clk_o), .clock_oe(clk_oe),
        .data_o(dat_o), .data_oe(dat_oe), .ext_memory_disable(ext_memory_disable), .board_power_n(board_power_n),
        .board_gang(board_gang), .power_source_strap_n(strap_n), .data_in(data_in), .dplus_level(dplus_level),
        .clock_level(clock_level));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_cnt(input string name, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic do_reset(input int n);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        #1;
        chk_val("pullup_oe", 32'h0, 32'(pu_oe));
        chk_val("dplus", 32'h0, 32'(dplus_level));
        chk_val("port_power_n", 32'h7, 32'(port_power_n));
        @(posedge aclk);
        aresetn <= 1'b1;
        c = 0;
        do begin
            @(posedge aclk);
            c++;
            #1;
        end while (pu_oe !== 1'b1 && c < HOLD + 50);
        chk_cnt("holdoff", HOLD + 1, c);
        chk_val("dplus", 32'h1, 32'(dplus_level));
        @(posedge aclk);
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        do_reset(20);
        axi_rd(MEM_CTRL_OFS, rd, rs);
        chk_val("mem_ctrl_rst", 32'(MEM_CTRL_RST), rd);
        axi_wr(ID_LOAD_OFS, 32'h12345678, rs);
        foreach (rows[i]) begin
            axi_wr(MEM_CTRL_OFS, 32'(rows[i].mc), rs);
            board_power_n <= rows[i].strap_n;
            ext_memory_disable <= rows[i].ext;
            board_gang <= rows[i].gang;
            repeat (8) @(posedge aclk);
            #1;
            chk_val("self_powered", 32'(rows[i].strap_n), 32'(self_powered));
            chk_val("clock_oe", 32'(rows[i].exp[3]), 32'(clk_oe));
            chk_val("data_oe", 32'(rows[i].exp[2]), 32'(dat_oe));
            chk_val("clock_level", 32'(rows[i].exp[0]), 32'(clock_level));
            @(posedge aclk);
            axi_rd(STATUS_OFS, rd, rs);
            chk_val("st_self", 32'(rows[i].strap_n), 32'(rd[ST_SELF]));
            chk_val("st_extdis", 32'(rows[i].ext), 32'(rd[ST_EXTDIS]));
            chk_val("st_gang", 32'(rows[i].exp[4]), 32'(rd[ST_GANG]));
            chk_val("st_din", 32'(rows[i].exp[1]), 32'(rd[ST_MEMDIN]));
            axi_rd(ID_OFS, rd, rs);
            chk_val("id", rows[i].ext ? {DEFAULT_PID, DEFAULT_VID} : 32'h12345678, rd);
        end
        for (int m = 0; m < 2; m++) begin
            ext_memory_disable <= 1'b1;
            board_gang <= m[0];
            repeat (8) @(posedge aclk);
            axi_wr(PORT_CTRL_OFS, 32'h7, rs);
            repeat (4) @(posedge aclk);
            #1;
            chk_val("power_on", 32'h0, 32'(port_power_n));
            @(posedge aclk);
            overcurrent_n <= m ? 3'b110 : 3'b101;
            repeat (2) @(posedge aclk);
            overcurrent_n <= 3'b111;
            repeat (4) @(posedge aclk);
            #1;
            chk_val("power_trip", m ? 32'h7 : 32'h2, 32'(port_power_n));
            @(posedge aclk);
            axi_rd(STATUS_OFS, rd, rs);
            chk_val("trip_flags", m ? 32'h7 : 32'h2, 32'(rd[ST_TRIP_LSB +: 3]));
            axi_wr(TRIP_CLR_OFS, 32'h7, rs);
            repeat (4) @(posedge aclk);
            #1;
            chk_val("power_clear", 32'h0, 32'(port_power_n));
            @(posedge aclk);
        end
        axi_wr(8'h20, 32'h1, rs);
        chk_val("bresp_unmapped", 32'(RESP_SLVERR), 32'(rs));
        axi_wr(STATUS_OFS, 32'h1, rs);
        chk_val("bresp_ro", 32'(RESP_SLVERR), 32'(rs));
        axi_rd(8'h20, rd, rs);
        chk_val("rresp_unmapped", 32'(RESP_SLVERR), 32'(rs));
        chk_val("rdata_unmapped", 32'h0, rd);
        repeat (HOLD + 10) @(posedge aclk);
        for (int k = 0; k < 2; k++) begin
            board_power_n <= ~board_power_n;
            c = 0;
            do begin
                @(posedge aclk);
                c++;
                #1;
                if (c == 4) begin
                    chk_val("pullup_float", 32'h0, 32'(pu_oe));
                end
            end while ((c <= 4 || pu_oe !== 1'b1) && c < HOLD + 50);
            chk_cnt("restart", HOLD + 4, c);
            @(posedge aclk);
        end
        do_reset(4);
        wrap_up();
    end
endmodule
`default_nettype wire
